// *** hw/diffq_defs.svh ***
// Constants for the difference and quadrature calculator.
`ifndef DIFFQ_DEFS_SVH
`define DIFFQ_DEFS_SVH
`define CODE_W        12
`define DIFF_W        13
`define STEP_W        10
`define FRAME_BITS    32
`define LEAD_ZEROS    3
`define HALF_BITS     16
`define QUAD_CHAN_SEL 3'h6
`define STEP_RST      10'h000
`endif

// *** hw/diffq_pkg.sv ***
// Types shared by the difference and quadrature calculator.
`include "diffq_defs.svh"
package diffq_pkg;
  typedef logic [`CODE_W-1:0] code_t;
  typedef logic [`DIFF_W-1:0] diff_t;
  typedef logic [`STEP_W-1:0] step_t;
endpackage

// *** hw/sync2.sv ***
// Two flip-flop level synchroniser.
`timescale 1ns/1ns
module sync2
  import diffq_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_async,
  output logic      o_sync
);
  typedef struct packed
  {
    logic meta;
    logic sync;
  } sync_s;
  sync_s st_q;
  sync_s st_d;
  always_comb
  begin
    st_d.meta = i_async;
    st_d.sync = st_q.meta;
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign o_sync = st_q.sync;
endmodule

// *** hw/diffq_calc.sv ***
// Difference and quadrature calculator with its serial read-out frame.
`timescale 1ns/1ns
`include "diffq_defs.svh"

// Behaviour
// - The difference is code A minus code B.
// - The difference is only meaningful for straight binary codes.
// - The difference is a 13-bit two's complement word, sign first.
// - The delivered difference is A minus B minus one.
// - Phase A and phase B bits split each period into four quadrants.
// - The direction bit is low for the reference sense, high otherwise.
// - A 10-bit step counter is reported with phase and direction bits.
// - The counter counts up twice per period at direction 0, down at 1.
// - After select falls three zeros then 12 result bits are shifted.
// - Held low 16 more clocks, the line gives the second word, then idles.
module diffq_calc
  import diffq_pkg::*;
(
  input  wire logic  i_ref_clk,
  input  wire logic  i_resetn,
  input  wire logic  i_sclk,
  input  wire logic  i_chip_select_n,
  input  wire code_t i_code_a,
  input  wire code_t i_code_b,
  input  wire logic  i_code_valid,
  input  wire logic  i_phase_a_in,
  input  wire logic  i_phase_b_in,
  input  wire logic  i_input_type_select,
  input  wire logic  i_channel_address_bit2,
  input  wire logic  i_channel_address_bit1,
  input  wire logic  i_channel_address_bit0,
  output logic       o_serial_out_a,
  output logic       o_serial_out_a_oen,
  output logic       o_serial_out_b,
  output logic       o_serial_out_b_oen,
  output diff_t      o_diff,
  output step_t      o_step_count,
  output logic       o_direction,
  output logic       o_phase_a,
  output logic       o_phase_b,
  output logic       o_quad_active
);
  // ------------------------------------------------------------
  // Core domain: difference and quadrature tracking
  // ------------------------------------------------------------
  typedef struct packed
  {
    diff_t diff;
    step_t step;
    logic  dir;
    logic  pa;
    logic  pb;
  } core_s;
  core_s c_q;
  core_s c_d;
  logic pa_s;
  logic pb_s;
  logic quad_en;
  logic fwd;
  logic rev;

  sync2 u_sync_pa
  (
    .i_clk    (i_ref_clk),
    .i_resetn (i_resetn),
    .i_async  (i_phase_a_in),
    .o_sync   (pa_s)
  );
  sync2 u_sync_pb
  (
    .i_clk    (i_ref_clk),
    .i_resetn (i_resetn),
    .i_async  (i_phase_b_in),
    .o_sync   (pb_s)
  );

  assign quad_en = !i_input_type_select &&
                   ({i_channel_address_bit2, i_channel_address_bit1,
                     i_channel_address_bit0} == `QUAD_CHAN_SEL);
  // Gray-sequence steps: 00,10,11,01 is A leading B.
  assign fwd = (pa_s != c_q.pa) && (pb_s == c_q.pb) && (pa_s != pb_s)
             || (pb_s != c_q.pb) && (pa_s == c_q.pa) && (pa_s == pb_s);
  assign rev = (pa_s != c_q.pa) && (pb_s == c_q.pb) && (pa_s == pb_s)
             || (pb_s != c_q.pb) && (pa_s == c_q.pa) && (pa_s != pb_s);

  always_comb
  begin
    c_d = c_q;
    if (i_code_valid)
    begin
      // Codes are taken as straight binary; fully differential codes
      // give a meaningless result.
      c_d.diff = diff_t'({1'b0, i_code_a} - {1'b0, i_code_b}
                         - 13'h0001);
    end
    c_d.pa = pa_s;
    c_d.pb = pb_s;
    if (quad_en)
    begin
      if (fwd)
        c_d.dir = 1'b0;
      else if (rev)
        c_d.dir = 1'b1;
      // Counting on phase A edges only gives two counts per period.
      if (pa_s != c_q.pa && (fwd || rev))
      begin
        if (fwd)
          c_d.step = c_q.step + 10'h001;
        else
          c_d.step = c_q.step - 10'h001;
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      c_q.diff <= '0;
      c_q.step <= `STEP_RST;
      c_q.dir  <= 1'b0;
      c_q.pa   <= 1'b0;
      c_q.pb   <= 1'b0;
    end
    else
      c_q <= c_d;
  end

  assign o_diff        = c_q.diff;
  assign o_step_count  = c_q.step;
  assign o_direction   = c_q.dir;
  assign o_phase_a     = c_q.pa;
  assign o_phase_b     = c_q.pb;
  assign o_quad_active = quad_en;

  // ------------------------------------------------------------
  // Snapshot handshake toward the serial clock domain
  // ------------------------------------------------------------
  // The words are copied into three holding words when select is high, so
  // they stand still for the whole frame while the link samples them.
  typedef struct packed
  {
    logic [`HALF_BITS-1:0] word_a;
    logic [`HALF_BITS-1:0] first_b;
    logic [`HALF_BITS-1:0] word_b;
  } hold_s;
  hold_s h_q;
  hold_s h_d;
  logic  cs_s;
  logic [`HALF_BITS-1:0] second_word;

  sync2 u_sync_cs
  (
    .i_clk    (i_ref_clk),
    .i_resetn (i_resetn),
    .i_async  (i_chip_select_n),
    .o_sync   (cs_s)
  );

  // Quadrature word: phase A, phase B, direction, count.
  assign second_word = quad_en ?
    {3'h0, c_q.pa, c_q.pb, c_q.dir, c_q.step} :
    {3'h0, c_q.diff};
  always_comb
  begin
    h_d = h_q;
    if (cs_s)
    begin
      h_d.word_a = {`LEAD_ZEROS'(0), i_code_a, 1'b0};
      // Each line leads with its own converter's code.
      h_d.first_b = {`LEAD_ZEROS'(0), i_code_b, 1'b0};
      h_d.word_b = second_word;
    end
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_resetn)
      h_q <= '0;
    else
      h_q <= h_d;
  end

  // ------------------------------------------------------------
  // Link domain: frame counter on the serial clock
  // ------------------------------------------------------------
  // Holding words are quasi-static during a frame, so sampling them
  // here is safe as long as the host keeps select high between frames.
  typedef struct packed
  {
    logic [5:0] cnt;
    logic       active;
    logic       out_a;
    logic       out_b;
  } link_s;
  link_s l_q;
  link_s l_d;
  logic [`FRAME_BITS-1:0] frame_a;
  logic [`FRAME_BITS-1:0] frame_b;

  assign frame_a = {h_q.word_a, h_q.word_b};
  assign frame_b = {h_q.first_b, h_q.word_b};

  always_comb
  begin
    l_d = l_q;
    if (l_q.active)
    begin
      l_d.cnt = l_q.cnt + 6'h01;
      if (l_q.cnt < 6'(`FRAME_BITS - 1))
      begin
        l_d.out_a = frame_a[5'(`FRAME_BITS - 2) - 5'(l_q.cnt)];
        l_d.out_b = frame_b[5'(`FRAME_BITS - 2) - 5'(l_q.cnt)];
      end
      else
        l_d.active = 1'b0;
    end
  end

  // Select acts as the frame's own reset so nothing depends on edges
  // of a clock that stops between frames.
  always_ff @(negedge i_sclk or posedge i_chip_select_n)
  begin
    if (i_chip_select_n)
    begin
      l_q.cnt    <= 6'h00;
      l_q.active <= 1'b1;
      l_q.out_a  <= 1'b0;
      l_q.out_b  <= 1'b0;
    end
    else
      l_q <= l_d;
  end

  assign o_serial_out_a     = l_q.out_a;
  assign o_serial_out_b     = l_q.out_b;
  assign o_serial_out_a_oen = i_chip_select_n || !l_q.active;
  assign o_serial_out_b_oen = i_chip_select_n || !l_q.active;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // A counting step is a phase A edge that also fits the gray order.
  sequence fwd_count_s;
    quad_en && fwd && (pa_s != c_q.pa);
  endsequence
  sequence rev_count_s;
    quad_en && rev && (pa_s != c_q.pa);
  endsequence
  // Both phases moving in one cycle is a skipped quadrant, not a step.
  sequence phase_jump_s;
    quad_en && (pa_s != c_q.pa) && (pb_s != c_q.pb);
  endsequence

  step_count_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    !quad_en |=> $stable(c_q.step))
    else $error("step count moved outside quadrature mode");

  diff_value_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    i_code_valid |=> c_q.diff == diff_t'({1'b0, $past(i_code_a)}
      - {1'b0, $past(i_code_b)} - 13'h0001))
    else $error("difference is not A minus B minus one");

  step_up_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    fwd_count_s |=> c_q.step == $past(c_q.step) + 10'h001)
    else $error("step count did not increment");

  step_down_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    rev_count_s |=> c_q.step == $past(c_q.step) - 10'h001)
    else $error("step count did not decrement");

  jump_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    phase_jump_s |=> $stable(c_q.step) && $stable(c_q.dir))
    else $error("count or direction moved on a phase jump");

  dir_fwd_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    quad_en && fwd |=> !c_q.dir)
    else $error("direction not low for reference sense");

  dir_rev_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    quad_en && rev |=> c_q.dir)
    else $error("direction not high for opposite sense");

  phase_track_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    1'b1 |=> c_q.pa == $past(pa_s) && c_q.pb == $past(pb_s))
    else $error("phase bits do not follow inputs");

  lead_zero_a: assert property (
    @(negedge i_sclk) disable iff (i_chip_select_n)
    l_q.active && l_q.cnt < 6'(`LEAD_ZEROS) |-> !l_q.out_a && !l_q.out_b)
    else $error("leading zero missing");

  // The line drives until the last fall and is released right after it.
  frame_end_a: assert property (
    @(posedge i_sclk) disable iff (i_chip_select_n)
    o_serial_out_a_oen == (l_q.cnt == 6'(`FRAME_BITS)))
    else $error("line not released at frame end");
endmodule

// *** bench/host_reader.sv ***
// Host model that clocks one read frame out of the calculator.
`timescale 1ns/1ns
module host_reader
(
  output logic      o_sclk,
  output logic      o_chip_select_n,
  input  wire logic i_serial_out_a,
  input  wire logic i_serial_out_b,
  input  wire logic i_serial_out_a_oen,
  input  wire logic i_serial_out_b_oen
);
  // ----------
  // Frame read
  // ----------
  // The serial clock idles high and stands still between frames.
  initial
  begin
    o_sclk = 1'b1;
    o_chip_select_n = 1'b1;
  end

  task automatic read_frame(output logic [31:0] o_a, output logic [31:0] o_b,
                            output logic o_drove, output logic o_gone);
    o_drove = 1'b1;
    // Select stays high over several core cycles so the snapshot settles.
    // The offset keeps serial edges away from the core clock edges.
    #207;
    o_chip_select_n = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      #62;
      // A released line reads as the inverse of the last driven bit.
      o_a[i] = i_serial_out_a ^ i_serial_out_a_oen;
      o_b[i] = i_serial_out_b ^ i_serial_out_b_oen;
      o_drove = o_drove & ~i_serial_out_a_oen & ~i_serial_out_b_oen;
      o_sclk = 1'b0;
      #63;
      o_sclk = 1'b1;
    end
    #10;
    o_gone = i_serial_out_a_oen & i_serial_out_b_oen;
    #52;
    o_chip_select_n = 1'b1;
  endtask
endmodule

// *** bench/adc_difference_quadrature_calc_test.sv ***
// Self-checking bench for the difference and quadrature calculator.
`timescale 1ns/1ns
module adc_difference_quadrature_calc_test;
  import diffq_pkg::*;
  logic        clk, resetn, valid, pa, pb, tsel, ad2, ad1, ad0;
  logic        sclk, cs_n, sa, sa_oen, sb, sb_oen, dir, qpa, qpb, qon;
  code_t       ca, cb;
  diff_t       diff;
  step_t       cnt, cnt_exp;
  logic [31:0] seed, fa, fb;
  logic        drove, gone;
  integer      n_errors, checked;

  always #25 clk = ~clk;

  diffq_calc i_diffq_calc (.i_ref_clk(clk), .i_resetn(resetn), .i_sclk(sclk),
    .i_chip_select_n(cs_n), .i_code_a(ca), .i_code_b(cb),
    .i_code_valid(valid), .i_phase_a_in(pa), .i_phase_b_in(pb),
    .i_input_type_select(tsel), .i_channel_address_bit2(ad2),
    .i_channel_address_bit1(ad1), .i_channel_address_bit0(ad0),
    .o_serial_out_a(sa), .o_serial_out_a_oen(sa_oen), .o_serial_out_b(sb),
    .o_serial_out_b_oen(sb_oen), .o_diff(diff), .o_step_count(cnt),
    .o_direction(dir), .o_phase_a(qpa), .o_phase_b(qpb),
    .o_quad_active(qon));

  host_reader i_host_reader (.o_sclk(sclk), .o_chip_select_n(cs_n),
    .i_serial_out_a(sa), .i_serial_out_b(sb), .i_serial_out_a_oen(sa_oen),
    .i_serial_out_b_oen(sb_oen));

  // -------
  // Helpers
  // -------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04000007 : 32'h0);
  endfunction

  function automatic diff_t exp_diff(input code_t a, input code_t b);
    return {1'b0, a} - {1'b0, b} - 13'h0001;
  endfunction

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic frame(input logic [12:0] low);
    logic [31:0] e;
    e = {3'h0, ca, 4'h0, low};
    i_host_reader.read_frame(fa, fb, drove, gone);
    check("frame_a", fa, e);
    check("frame_b", fb, {3'h0, cb, 4'h0, low});
    check("driving", drove, 1'b1);
    check("released", gone, 1'b1);
  endtask

  task automatic diff_case(input code_t a, input code_t b);
    @(negedge clk);
    ca = a;
    cb = b;
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    @(negedge clk);
    check("diff", diff, exp_diff(a, b));
    frame(exp_diff(a, b));
  endtask

  task automatic step(input logic [1:0] s, input logic en);
    @(negedge clk);
    {pa, pb} = s;
    repeat (4) @(negedge clk);
    if (en)
      check("phase", {qpa, qpb}, s);
  endtask

  // Counting is expected only while the quadrature decode is selected.
  task automatic periods(input int n, input logic rev, input logic en);
    logic [1:0] seq [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    repeat (n)
      for (int k = 0; k < 4; k++)
        step(seq[rev ? (6 - k) % 4 : k], en);
    if (en)
    begin
      cnt_exp = rev ? cnt_exp - step_t'(2 * n) : cnt_exp + step_t'(2 * n);
      check("dir", dir, rev);
    end
    check("count", cnt, cnt_exp);
  endtask

  // -----
  // Tests
  // -----
  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    {valid, pa, pb, tsel, ad2, ad1, ad0} = 7'h08;
    {ca, cb} = 24'h0;
    n_errors = 0;
    checked = 0;
    seed = 32'h3E7A;
    cnt_exp = 10'h000;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    check("diff_rst", diff, 13'h0000);
    check("count_rst", cnt, 10'h000);
    $display("reset test done");
    diff_case(12'hAAA, 12'hCCC);
    check("diff_known", diff, 13'h1DDD);
    diff_case(12'h000, 12'h000);
    diff_case(12'hFFF, 12'h000);
    diff_case(12'h000, 12'hFFF);
    repeat (6)
    begin
      seed = lfsr(seed);
      diff_case(seed[11:0], seed[27:16]);
    end
    $display("difference test done");
    @(negedge clk);
    {tsel, ad2, ad1, ad0} = 4'h6;
    @(negedge clk);
    check("quad_on", qon, 1'b1);
    periods(2, 1'b0, 1'b1);
    periods(4, 1'b1, 1'b1);
    frame({2'h0, 1'b1, cnt_exp});
    repeat (3)
    begin
      seed = lfsr(seed);
      periods(1 + seed[1:0], seed[4], 1'b1);
    end
    // Both phases jump at once: such a move must be ignored.
    @(negedge clk);
    {pa, pb} = 2'h3;
    repeat (4) @(negedge clk);
    {pa, pb} = 2'h0;
    repeat (4) @(negedge clk);
    check("jump", cnt, cnt_exp);
    {tsel, ad2, ad1, ad0} = 4'h7;
    periods(2, 1'b0, 1'b0);
    check("quad_off", qon, 1'b0);
    {tsel, ad2, ad1, ad0} = 4'hE;
    @(negedge clk);
    check("quad_type", qon, 1'b0);
    $display("quadrature test done");
    // Reset again in mid-run and count afresh from zero.
    resetn = 1'b0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    cnt_exp = 10'h000;
    check("count_rst2", cnt, cnt_exp);
    check("diff_rst2", diff, 13'h0000);
    check("dir_rst2", dir, 1'b0);
    {tsel, ad2, ad1, ad0} = 4'h6;
    periods(1, 1'b0, 1'b1);
    frame({3'h0, cnt_exp});
    $display("second reset test done");
    final_report();
  end

  initial
  begin
    #2000000;
    n_errors++;
    final_report();
  end
endmodule
